// ---- logic/pdm_pin_mux.v ----
// Pin function multiplexer for port D pins 8-11 and port E pins 12-13
//
// Summary of operation
// RL1: D11 code 000 port, 001 bus, 100 timer.
// RL2: D10 code 000 port, 001 bus, 100 timer.
// RL3: D9 code 000 port, 001 bus, 100 timer.
// RL4: Software writes only listed codes per pin.
// RL5: Reserved bits read zero, written zero.
// RL6: Codes reset 000; LSB 1 in romless boot.
// RL7: E13 000 port, 011 manual reset, 110 timer.
// RL8: E12 000 port, 110 timer, rest prohibited.
// RL9: Standby: D9, D11 float unless hold set.
// RL10: Prohibited code keeps pin as port.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_consts.vh"

module pdm_pin_mux (
    // Clock and reset
    input  wire                   clk_sys,
    input  wire                   reset_n,

    // Register port
    input  wire [`PDM_ADDR_W-1:0] reg_addr,
    input  wire [15:0]            reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [15:0]            reg_rdata,

    // System control
    input  wire                   boot_ext_romless,
    input  wire                   standby_mode,
    output reg                    manual_reset_input_n,

    // Pins, index 0..5 = D8, D9, D10, D11, E12, E13
    input  wire [5:0]             pin_in,
    output wire [5:0]             pin_out,
    output wire [5:0]             pin_oe,

    // General port side
    input  wire [5:0]             port_out,
    input  wire [5:0]             port_oe,
    output reg  [5:0]             port_in,

    // External bus controller data lines 8..11
    input  wire [3:0]             bus_d_out,
    input  wire [3:0]             bus_d_oe,
    output reg  [3:0]             bus_d_in,

    // Secondary motor timer channel 3 B, C, D
    input  wire                   sec_timer_ch3_b_signal_out,
    input  wire                   sec_timer_ch3_b_signal_oe,
    output reg                    sec_timer_ch3_b_signal_in,
    input  wire                   sec_timer_ch3_c_signal_out,
    input  wire                   sec_timer_ch3_c_signal_oe,
    output reg                    sec_timer_ch3_c_signal_in,
    input  wire                   sec_timer_ch3_d_signal_out,
    input  wire                   sec_timer_ch3_d_signal_oe,
    output reg                    sec_timer_ch3_d_signal_in,

    // Main motor timer channel 4 A, B
    input  wire                   main_timer_ch4_a_signal_out,
    input  wire                   main_timer_ch4_a_signal_oe,
    output reg                    main_timer_ch4_a_signal_in,
    input  wire                   main_timer_ch4_b_signal_out,
    input  wire                   main_timer_ch4_b_signal_oe,
    output reg                    main_timer_ch4_b_signal_in
);

    // Codes are stored as written, prohibited ones too, so reads
    // return what was written; only the routing refuses them and
    // keeps such a pin with the port, with no error flag raised.
    //
    // Code to routing; port first, unknown codes fall back to port [RL10]
    function [1:0] route_of;
        input [2:0] code;
        input [2:0] alt1_code;
        input [2:0] alt2_code;
        begin
            if (code == `PDM_CODE_PORT)
                route_of = `PDM_SEL_PORT;
            else if (code == alt1_code)
                route_of = `PDM_SEL_ALT1;
            else if (code == alt2_code)
                route_of = `PDM_SEL_ALT2;
            else
                route_of = `PDM_SEL_PORT;
        end
    endfunction

    // Stored state: function registers, hold bit, strap capture;
    // routing is decoded from these afresh every cycle
    reg  [15:0] port_d_function_select_low3_q;
    reg  [15:0] port_e_function_select_q;
    reg         port_d_low_standby_hold_q;
    reg  [1:0]  strap_sync_q;
    reg  [1:0]  strap_cnt_q;
    reg  [15:0] rdata_d;

    // Per-pin vectors run D8, D9, D10, D11, E12, E13; route holds
    // two bits a pin in the same order
    wire [2:0]  pin_d8_function_code;
    wire [2:0]  pin_d9_function_code;
    wire [2:0]  pin_d10_function_code;
    wire [2:0]  pin_d11_function_code;
    wire [2:0]  pin_e12_function_code;
    wire [2:0]  pin_e13_function_code;
    wire [11:0] route;
    wire [5:0]  in_sync;
    wire [5:0]  float_en;
    wire [5:0]  alt1_out;
    wire [5:0]  alt1_oe;
    wire [5:0]  alt2_out;
    wire [5:0]  alt2_oe;
    wire        strap_load;

    // Code fields of the function registers
    assign pin_d8_function_code  = port_d_function_select_low3_q[`PDM_POS_D8 +: 3];
    assign pin_d9_function_code  = port_d_function_select_low3_q[`PDM_POS_D9 +: 3];
    assign pin_d10_function_code = port_d_function_select_low3_q[`PDM_POS_D10 +: 3];
    assign pin_d11_function_code = port_d_function_select_low3_q[`PDM_POS_D11 +: 3];
    assign pin_e12_function_code = port_e_function_select_q[`PDM_POS_E12 +: 3];
    assign pin_e13_function_code = port_e_function_select_q[`PDM_POS_E13 +: 3];

    // Route codes: 0 port, 1 first alternative, 2 second. D8 has no
    // timer, so its second code repeats the bus code and never wins;
    // E12 has no first alternative, the port code makes it unreachable.
    //
    // Effective routing per pin, two bits each
    assign route[1:0]   = route_of(pin_d8_function_code, `PDM_CODE_BUS, `PDM_CODE_BUS);
    assign route[3:2]   = route_of(pin_d9_function_code, `PDM_CODE_BUS, `PDM_CODE_STMR);  // [RL3]
    assign route[5:4]   = route_of(pin_d10_function_code, `PDM_CODE_BUS, `PDM_CODE_STMR); // [RL2]
    assign route[7:6]   = route_of(pin_d11_function_code, `PDM_CODE_BUS, `PDM_CODE_STMR); // [RL1]
    assign route[9:8]   = route_of(pin_e12_function_code, `PDM_CODE_PORT, `PDM_CODE_MTMR); // [RL8]
    assign route[11:10] = route_of(pin_e13_function_code, `PDM_CODE_MANUAL_RESET_INPUT_N, `PDM_CODE_MTMR); // [RL7]

    // Manual reset on E13 is input only: its enable is tied low, so
    // the pin is undriven and must be pulled idle from outside.
    //
    // First alternative: bus data on port D, nothing driven on port E
    assign alt1_out = {2'b00, bus_d_out};
    assign alt1_oe  = {2'b00, bus_d_oe};

    // Second alternative: timer compare/capture signals
    assign alt2_out = {main_timer_ch4_b_signal_out, main_timer_ch4_a_signal_out,
                       sec_timer_ch3_d_signal_out, sec_timer_ch3_b_signal_out,
                       sec_timer_ch3_c_signal_out, 1'b0};
    assign alt2_oe  = {main_timer_ch4_b_signal_oe, main_timer_ch4_a_signal_oe,
                       sec_timer_ch3_d_signal_oe, sec_timer_ch3_b_signal_oe,
                       sec_timer_ch3_c_signal_oe, 1'b0};

    // Hold bit 0 floats the low group in standby, 1 keeps its level;
    // the other four pins keep their state whatever the bit says.
    //
    // Only D9 and D11 may float in standby; the rest always keep state
    assign float_en = {2'b00, ~port_d_low_standby_hold_q, 1'b0,
                       ~port_d_low_standby_hold_q, 1'b0}; // [RL9]

    // Drive is registered in each cell, so a new code or driver shows
    // on the pin one cycle later; inputs take three cycles to reach
    // the function side (two synchroniser stages, one routing stage).
    //
    // Six pin cells
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_pin
            pdm_pin_cell u_cell (
                .clk_sys          (clk_sys),
                .reset_n          (reset_n),
                .sel              (route[2*gi +: 2]),
                .standby          (standby_mode),
                .float_in_standby (float_en[gi]),
                .port_out         (port_out[gi]),
                .port_oe          (port_oe[gi]),
                .alt1_out         (alt1_out[gi]),
                .alt1_oe          (alt1_oe[gi]),
                .alt2_out         (alt2_out[gi]),
                .alt2_oe          (alt2_oe[gi]),
                .pin_in           (pin_in[gi]),
                .pin_out          (pin_out[gi]),
                .pin_oe           (pin_oe[gi]),
                .pin_in_sync      (in_sync[gi])
            );
        end
    endgenerate

    // The strap is a pin level, so it is synchronised first. The load
    // waits until both stages hold post-release values, fires once and
    // stops. A port D write in that cycle is lost, so software should
    // leave the register alone for the first few cycles.
    //
    // Boot strap synchroniser and load counter; strap caught after release
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            strap_sync_q <= 2'b00;
            strap_cnt_q  <= 2'h0;
        end else begin
            strap_sync_q <= {strap_sync_q[0], boot_ext_romless};
            if (strap_cnt_q != 2'h3)
                strap_cnt_q <= strap_cnt_q + 2'h1;
        end
    end

    assign strap_load = (strap_cnt_q == `PDM_STRAP_LOAD_CNT);

    // Reserved bits are masked on the way in, not on reads, so stored
    // and read values never differ. Strap load beats a port D write;
    // port E and hold writes are never blocked.
    //
    // Function and hold registers; reserved bits never stored [RL5]
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            port_d_function_select_low3_q <= `PDM_PDFS_RST; // [RL6]
            port_e_function_select_q      <= `PDM_PEFS_RST; // [RL7] [RL8]
            port_d_low_standby_hold_q     <= `PDM_HOLD_RST;
        end else begin
            if (strap_load) begin
                // Romless external boot sets each code LSB, selecting bus data
                port_d_function_select_low3_q <= strap_sync_q[1] ?
                    `PDM_PDFS_ROMLESS : `PDM_PDFS_RST; // [RL6]
            end else if (reg_wr && reg_addr == `PDM_OFS_PDFS) begin
                port_d_function_select_low3_q <= reg_wdata & `PDM_PDFS_WMASK; // [RL5]
            end
            if (reg_wr && reg_addr == `PDM_OFS_PEFS)
                port_e_function_select_q <= reg_wdata & `PDM_PEFS_WMASK; // [RL5]
            if (reg_wr && reg_addr == `PDM_OFS_HOLD)
                port_d_low_standby_hold_q <= reg_wdata[`PDM_POS_HOLD_DL];
        end
    end

    // Routing register is read only; writes to it or to unmapped
    // offsets are ignored, and unused space never echoes stale data.
    //
    // Read decode; unmapped addresses read zero
    always @* begin
        rdata_d = 16'h0000;
        case (reg_addr)
            `PDM_OFS_PDFS:  rdata_d = port_d_function_select_low3_q;
            `PDM_OFS_PEFS:  rdata_d = port_e_function_select_q;
            `PDM_OFS_HOLD:  rdata_d[`PDM_POS_HOLD_DL] = port_d_low_standby_hold_q;
            `PDM_OFS_ROUTE: rdata_d = {4'h0, route};
            default:        rdata_d = 16'h0000;
        endcase
    end

    // Zero between reads exposes a master that samples a cycle late,
    // and keeps the bus quiet when nobody reads
    //
    // Read data stands only in the cycle after the strobe
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // A function that does not own a pin sees a constant idle level,
    // never the pin: a timer input cannot capture edges caused by port
    // traffic on a shared pin.
    //
    // Input routing; a function not selected sees an idle level
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            port_in                    <= 6'h00;
            bus_d_in                   <= 4'h0;
            sec_timer_ch3_b_signal_in  <= 1'b0;
            sec_timer_ch3_c_signal_in  <= 1'b0;
            sec_timer_ch3_d_signal_in  <= 1'b0;
            main_timer_ch4_a_signal_in <= 1'b0;
            main_timer_ch4_b_signal_in <= 1'b0;
            manual_reset_input_n       <= 1'b1;
        end else begin
            port_in[0] <= (route[1:0] == `PDM_SEL_PORT) & in_sync[0];
            port_in[1] <= (route[3:2] == `PDM_SEL_PORT) & in_sync[1];
            port_in[2] <= (route[5:4] == `PDM_SEL_PORT) & in_sync[2];
            port_in[3] <= (route[7:6] == `PDM_SEL_PORT) & in_sync[3];
            port_in[4] <= (route[9:8] == `PDM_SEL_PORT) & in_sync[4];
            port_in[5] <= (route[11:10] == `PDM_SEL_PORT) & in_sync[5];

            bus_d_in[0] <= (route[1:0] == `PDM_SEL_ALT1) & in_sync[0];
            bus_d_in[1] <= (route[3:2] == `PDM_SEL_ALT1) & in_sync[1]; // [RL3]
            bus_d_in[2] <= (route[5:4] == `PDM_SEL_ALT1) & in_sync[2]; // [RL2]
            bus_d_in[3] <= (route[7:6] == `PDM_SEL_ALT1) & in_sync[3]; // [RL1]

            sec_timer_ch3_c_signal_in  <= (route[3:2] == `PDM_SEL_ALT2) & in_sync[1];
            sec_timer_ch3_b_signal_in  <= (route[5:4] == `PDM_SEL_ALT2) & in_sync[2];
            sec_timer_ch3_d_signal_in  <= (route[7:6] == `PDM_SEL_ALT2) & in_sync[3];
            main_timer_ch4_a_signal_in <= (route[9:8] == `PDM_SEL_ALT2) & in_sync[4];
            main_timer_ch4_b_signal_in <= (route[11:10] == `PDM_SEL_ALT2) & in_sync[5];
            // Manual reset is inactive high whenever E13 is not in that function
            manual_reset_input_n <= (route[11:10] == `PDM_SEL_ALT1) ?
                                    in_sync[5] : 1'b1; // [RL7]
        end
    end

endmodule // pdm_pin_mux

`default_nettype wire

// ---- logic/pdm_consts.vh ----
// Constants for the port D/E pin function multiplexer
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH

// Register offsets on the internal register port
`define PDM_ADDR_W          8
`define PDM_OFS_PDFS        8'h00
`define PDM_OFS_PEFS        8'h04
`define PDM_OFS_HOLD        8'h08
`define PDM_OFS_ROUTE       8'h0c

// Port D register field positions (LSB of each 3-bit code)
`define PDM_POS_D8          0
`define PDM_POS_D9          4
`define PDM_POS_D10         8
`define PDM_POS_D11         12
// Port E register field positions
`define PDM_POS_E12         0
`define PDM_POS_E13         4
// Hold register bit
`define PDM_POS_HOLD_DL     0

// Writable masks; reserved bits 15, 11, 7 and 3 stay zero
`define PDM_PDFS_WMASK      16'h7777
`define PDM_PEFS_WMASK      16'h0077
`define PDM_HOLD_WMASK      16'h0001

// Reset values
`define PDM_PDFS_RST        16'h0000
`define PDM_PDFS_ROMLESS    16'h1111
`define PDM_PEFS_RST        16'h0000
`define PDM_HOLD_RST        1'b0

// Function codes
`define PDM_CODE_PORT       3'h0
`define PDM_CODE_BUS        3'h1
`define PDM_CODE_MANUAL_RESET_INPUT_N       3'h3
`define PDM_CODE_STMR       3'h4
`define PDM_CODE_MTMR       3'h6

// Effective routing selections
`define PDM_SEL_PORT        2'h0
`define PDM_SEL_ALT1        2'h1
`define PDM_SEL_ALT2        2'h2

// Edges after reset release after which the boot strap is applied, on the next edge
`define PDM_STRAP_LOAD_CNT  2'h2

`endif

// ---- logic/pdm_pin_cell.v ----
// One multiplexed pin: output select, standby hold/float, input synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "pdm_consts.vh"

module pdm_pin_cell (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       reset_n,
    // Function select and standby control
    input  wire [1:0] sel,
    input  wire       standby,
    input  wire       float_in_standby,
    // Candidate drivers
    input  wire       port_out,
    input  wire       port_oe,
    input  wire       alt1_out,
    input  wire       alt1_oe,
    input  wire       alt2_out,
    input  wire       alt2_oe,
    // Pin side
    input  wire       pin_in,
    output reg        pin_out,
    output reg        pin_oe,
    output wire       pin_in_sync
);

    reg  [1:0] sync_q;
    reg        mux_out;
    reg        mux_oe;

    // Drivers of the selected function only; any other selection means port
    always @* begin
        case (sel)
            `PDM_SEL_ALT1: begin
                mux_out = alt1_out;
                mux_oe  = alt1_oe;
            end
            `PDM_SEL_ALT2: begin
                mux_out = alt2_out;
                mux_oe  = alt2_oe;
            end
            default: begin
                mux_out = port_out;
                mux_oe  = port_oe;
            end
        endcase
    end

    // Pin drive; in standby the last state is kept unless floating is asked for
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else if (!standby) begin
            pin_out <= mux_out;
            pin_oe  <= mux_oe;
        end else if (float_in_standby) begin
            pin_oe  <= 1'b0;
        end
    end

    // Two-stage synchroniser; only the second stage leaves the cell
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync_q <= 2'b00;
        end else begin
            sync_q <= {sync_q[0], pin_in};
        end
    end

    assign pin_in_sync = sync_q[1];

endmodule // pdm_pin_cell

`default_nettype wire

// ---- testbench/pdm_pin_mux_asserts.sv ----
// Checker for the port D/E pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "pdm_consts.vh"
module pdm_pin_mux_asserts (
    // Clock, reset, register port
    input wire logic                   clk_sys,
    input wire logic                   reset_n,
    input wire logic [`PDM_ADDR_W-1:0] reg_addr,
    input wire logic [15:0]            reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [15:0]            reg_rdata,
    // Standby, pins, drivers
    input wire logic                   standby_mode,
    input wire logic                   manual_reset_input_n,
    input wire logic [5:0]             pin_out,
    input wire logic [5:0]             pin_oe,
    input wire logic [5:0]             port_oe,
    input wire logic                   main_timer_ch4_a_signal_out,
    input wire logic                   main_timer_ch4_a_signal_oe
);
    logic [15:0] pe_q;
    logic        hold_q;
    // Shadow of registers no boot strap touches
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pe_q   <= 16'h0000;
            hold_q <= 1'b0;
        end else if (reg_wr && reg_addr == `PDM_OFS_PEFS) begin
            pe_q <= reg_wdata & `PDM_PEFS_WMASK;
        end else if (reg_wr && reg_addr == `PDM_OFS_HOLD) begin
            hold_q <= reg_wdata[0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_stby2;
        standby_mode ##1 standby_mode;
    endsequence
    sequence s_e12(logic [2:0] c);
        (pe_q[2:0] == c && !standby_mode) [*2];
    endsequence
    property p_rsv;
        reg_rd && reg_addr != `PDM_OFS_ROUTE |=> (reg_rdata & 16'h8888) == 16'h0000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
    property p_pe_read;
        reg_rd && reg_addr == `PDM_OFS_PEFS |=> reg_rdata == pe_q;
    endproperty
    a_pe_read: assert property (p_pe_read) else $error("port E readback wrong");
    property p_hold_read;
        reg_rd && reg_addr == `PDM_OFS_HOLD |=> reg_rdata == {15'h0000, hold_q};
    endproperty
    a_hold_read: assert property (p_hold_read) else $error("hold readback wrong");
    property p_e12_timer;
        s_e12(3'h6) |=> pin_oe[4] == $past(main_timer_ch4_a_signal_oe)
            && pin_out[4] == $past(main_timer_ch4_a_signal_out);
    endproperty
    a_e12_timer: assert property (p_e12_timer) else $error("E12 timer route");
    property p_e12_port;
        (pe_q[2:0] != 3'h6 && !standby_mode) [*2] |=> pin_oe[4] == $past(port_oe[4]);
    endproperty
    a_e12_port: assert property (p_e12_port) else $error("E12 port route");
    property p_e13_manual_reset_input_n;
        (pe_q[6:4] != 3'h3) [*2] |=> manual_reset_input_n;
    endproperty
    a_e13_manual_reset_input_n: assert property (p_e13_manual_reset_input_n) else $error("reset input active");
    property p_stby_float;
        (standby_mode && !hold_q) ##1 standby_mode |-> !pin_oe[1] && !pin_oe[3];
    endproperty
    a_stby_float: assert property (p_stby_float) else $error("D9/D11 driven");
    property p_stby_keep;
        s_stby2 |-> $stable(pin_out & 6'h35) && $stable(pin_oe & 6'h35);
    endproperty
    a_stby_keep: assert property (p_stby_keep) else $error("pin moved in standby");
endmodule // pdm_pin_mux_asserts
bind pdm_pin_mux pdm_pin_mux_asserts u_chk (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .standby_mode, .manual_reset_input_n, .pin_out,
    .pin_oe, .port_oe, .main_timer_ch4_a_signal_out, .main_timer_ch4_a_signal_oe);
`default_nettype wire

// ---- testbench/pdm_pin_model.sv ----
// Board model of the six shared pins
`timescale 1ns/1ps
`default_nettype none
module pdm_pin_model (
    // Clock and drives
    input  wire logic       clk_sys,
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] ext_val,
    input  wire logic [5:0] ext_en,
    // Level seen by the device
    output var  logic [5:0] pin_in
);
    logic [5:0] float_q = 6'h2a;
    // No pulls: released pins toggle so a stale read cannot match
    always @(posedge clk_sys) float_q <= ~float_q;
    // Device drive wins; outside drives only where asked
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & float_q)));
    end
endmodule // pdm_pin_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// Random and corner tests of the port D/E pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "pdm_consts.vh"
module testbench;
    logic        clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
    logic        boot_ext_romless = 0, standby_mode = 0;
    logic [7:0]  reg_addr = 0;
    logic [15:0] reg_wdata = 0, rd_val, pd, pe;
    logic [5:0]  port_out = 0, port_oe = 0, ext_val = 0, ext_en = 6'h3f, e_o, e_e, lv, so;
    logic [3:0]  bus_d_out = 0, bus_d_oe = 0;
    logic [5:0]  a2_o = 0, a2_e = 0; // Timer drive by pin index
    logic [31:0] r;
    wire  [15:0] reg_rdata;
    wire  [5:0]  pin_in, pin_out, pin_oe, port_in;
    wire  [3:0]  bus_d_in;
    wire  [5:1]  a2_i; // Timer inputs by pin index
    wire         manual_reset_input_n;
    int          n_errors = 0, cmp_count = 0, cyc = 0;
    pdm_pin_mux i_dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .boot_ext_romless, .standby_mode, .manual_reset_input_n, .pin_in,
        .pin_out, .pin_oe, .port_out, .port_oe, .port_in, .bus_d_out, .bus_d_oe, .bus_d_in,
        .sec_timer_ch3_b_signal_out(a2_o[2]), .sec_timer_ch3_b_signal_oe(a2_e[2]),
        .sec_timer_ch3_c_signal_out(a2_o[1]), .sec_timer_ch3_c_signal_oe(a2_e[1]),
        .sec_timer_ch3_d_signal_out(a2_o[3]), .sec_timer_ch3_d_signal_oe(a2_e[3]),
        .main_timer_ch4_a_signal_out(a2_o[4]), .main_timer_ch4_a_signal_oe(a2_e[4]),
        .main_timer_ch4_b_signal_out(a2_o[5]), .main_timer_ch4_b_signal_oe(a2_e[5]),
        .sec_timer_ch3_b_signal_in(a2_i[2]), .sec_timer_ch3_c_signal_in(a2_i[1]),
        .sec_timer_ch3_d_signal_in(a2_i[3]), .main_timer_ch4_a_signal_in(a2_i[4]),
        .main_timer_ch4_b_signal_in(a2_i[5]));
    pdm_pin_model i_pins (.clk_sys, .pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);
    initial forever #50 clk_sys = ~clk_sys;
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
        reg_rd <= 0;
        #1 rd_val = reg_rdata;
    endtask
    // 0 port, 1 bus or reset input, 2 timer
    function automatic int sel(int p, logic [2:0] c);
        if (p < 4) return c == 1 ? 1 : (c == 4 && p > 0) ? 2 : 0;
        if (p == 5 && c == 3) return 1;
        return c == 6 ? 2 : 0;
    endfunction
    task automatic run_mode();
        int s;
        logic [5:0]  bi, ti;
        logic [15:0] rt;
        rt = 16'h0000;
        bus(1, `PDM_OFS_PDFS, pd);
        bus(1, `PDM_OFS_PEFS, pe);
        bus(0, `PDM_OFS_PDFS, 0);
        chk("pd_readback", pd & 16'h7777, rd_val);
        bus(0, `PDM_OFS_PEFS, 0);
        chk("pe_readback", pe & 16'h0077, rd_val);
        r = $urandom;
        {port_out, port_oe, a2_o, a2_e, bus_d_out, bus_d_oe} <= r;
        ext_val <= 6'($urandom);
        repeat (7) @(posedge clk_sys);
        #1 for (int p = 0; p < 6; p++) begin
            s = sel(p, p < 4 ? pd[4*p+:3] : pe[4*(p-4)+:3]);
            e_o[p] = s == 0 ? port_out[p] : s == 2 ? a2_o[p] : p < 4 ? bus_d_out[p] : 0;
            e_e[p] = s == 0 ? port_oe[p] : s == 2 ? a2_e[p] : p < 4 ? bus_d_oe[p] : 0;
            lv[p] = e_e[p] ? e_o[p] : ext_val[p];
            bi[p] = (s == 1 && p < 4) ? lv[p] : 1'b0;
            ti[p] = s == 2 ? lv[p] : 1'b0;
            rt[2*p+:2] = 2'(s);
            if (s != 0) lv[p] = 0;
            if (p == 5) chk("manual_reset_input_n_n", s == 1 ? ext_val[5] : 1, manual_reset_input_n);
        end
        chk("pin_oe", e_e, pin_oe);
        chk("pin_out", e_o & e_e, pin_out & e_e);
        chk("port_in", lv, port_in);
        chk("bus_d_in", bi[3:0], bus_d_in);
        chk("timer_in", ti, {a2_i, 1'b0});
        bus(0, `PDM_OFS_ROUTE, 0);
        chk("route", rt, rd_val);
    endtask
    task automatic final_report();
        $display("counts: %0d mismatches in %0d comparisons", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        r = $urandom(32'hbc1f);
        repeat (6) @(posedge clk_sys);
        reset_n <= 1;
        repeat (5) @(posedge clk_sys);
        bus(0, `PDM_OFS_PDFS, 0);
        chk("pd_reset", 16'h0000, rd_val);
        bus(0, `PDM_OFS_PEFS, 0);
        chk("pe_reset", 16'h0000, rd_val);
        bus(0, `PDM_OFS_HOLD, 0);
        chk("hold_reset", 16'h0000, rd_val);
        bus(0, 8'h10, 0);
        chk("unmapped", 16'h0000, rd_val);
        $display("test reset_values done");
        // Every code in every field, random reserved bits, then mixed random codes
        for (int k = 0; k < 14; k++) begin
            r = $urandom;
            pd = k < 8 ? {4{1'b0, 3'(k)}} | (r[15:0] & 16'h8888) : r[15:0];
            pe = k < 8 ? {9'h000, 3'(k), 1'b0, 3'(k)} | (r[31:16] & 16'hff88) : r[31:16];
            run_mode();
        end
        $display("test function_codes done");
        bus(1, `PDM_OFS_PEFS, 0);
        for (int h = 0; h < 2; h++) begin
            pd = 0;
            bus(1, `PDM_OFS_PDFS, 0);
            bus(1, `PDM_OFS_HOLD, h);
            port_oe <= 6'h3f;
            repeat (4) @(posedge clk_sys);
            #1 so = pin_out;
            standby_mode <= 1;
            @(posedge clk_sys);
            port_out <= ~port_out;
            repeat (4) @(posedge clk_sys);
            #1 chk("stby_oe", h ? 6'h3f : 6'h35, pin_oe);
            chk("stby_out", so & 6'h35, pin_out & 6'h35);
            @(posedge clk_sys);
            standby_mode <= 0;
        end
        $display("test standby done");
        reset_n <= 0;
        boot_ext_romless <= 1;
        repeat (6) @(posedge clk_sys);
        reset_n <= 1;
        repeat (6) @(posedge clk_sys);
        bus(0, `PDM_OFS_PDFS, 0);
        chk("pd_strap", 16'h1111, rd_val);
        $display("test boot_strap done");
        final_report();
    end
endmodule // testbench
`default_nettype wire
